// >>> rtl/tsa_pkg.sv
/*
 * Shared constants for the thermometer scratchpad link: command codes,
 * scratchpad layout, configuration fields, power-up values, timing and the
 * controller's own register map.
 * Assumes both ends and the controller software agree on these values.
 */
package tsa_pkg;

	// ==========================================================
	// Function command codes
	localparam logic [7:0] CMD_CONVERT = 8'h44;
	localparam logic [7:0] CMD_COPY_SP = 8'h48;
	localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
	localparam logic [7:0] CMD_READ_SP = 8'hBE;
	localparam logic [7:0] CMD_RECALL = 8'hB8;
	localparam logic [7:0] CMD_READ_PWR = 8'hB4;

	// ==========================================================
	// Scratchpad layout
	localparam int SP_BITS = 72;
	localparam int SP_DATA_BITS = 64;
	localparam int ROM_DATA_BITS = 56;
	localparam int WR_BITS = 24;
	localparam logic [1:0] WBYTE_UPPER = 2'h0;
	localparam logic [1:0] WBYTE_LOWER = 2'h1;
	localparam logic [1:0] WBYTE_CFG = 2'h2;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int CMP_HI = 11;
	localparam int CMP_LO = 4;
	localparam int CFG_RES_LO = 5;
	localparam int CFG_RES_HI = 6;
	localparam logic CFG_TOP_VAL = 1'b0;
	localparam logic [4:0] CFG_LOW_VAL = 5'h1F;
	localparam logic [1:0] RES_MAX = 2'h3;
	localparam logic [7:0] RSV5_VAL = 8'hFF;
	localparam logic [7:0] RSV6_VAL = 8'h00;
	localparam logic [7:0] RSV7_VAL = 8'h10;
	localparam logic [15:0] TEMP_RESET = 16'h0550;
	localparam logic [7:0] NV_UPPER_INIT = 8'h7F;
	localparam logic [7:0] NV_LOWER_INIT = 8'h80;
	localparam logic [1:0] NV_RES_INIT = 2'h3;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

	// ==========================================================
	// Timing at the 200 MHz clock
	localparam int CLK_MHZ = 200;
	localparam int CONV_TIME_US = 750000;
	localparam int NV_WRITE_TIME_US = 10000;
	localparam int SPU_MAX_DELAY_US = 10;
	localparam int CONV_CYC_DEF = CONV_TIME_US * CLK_MHZ;
	localparam int NV_WR_CYC_DEF = NV_WRITE_TIME_US * CLK_MHZ;
	localparam int SPU_MAX_DELAY_CYC = SPU_MAX_DELAY_US * CLK_MHZ;
	localparam int RECALL_CYC = 16;

	// ==========================================================
	// Controller register map (APB, byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RDATA0 = 8'h0C;
	localparam logic [7:0] REG_RDATA1 = 8'h10;
	localparam logic [7:0] REG_RDATA2 = 8'h14;
	localparam int CTRL_GO = 8;
	localparam int CTRL_SPU = 9;
	localparam int CTRL_RES_LO = 10;
	localparam int CTRL_RES_HI = 11;
	localparam int CTRL_APOLL = 12;

	// ==========================================================
	// State codes
	typedef enum logic [6:0] {
		D_IDLE = 7'h01, D_WRITE = 7'h02, D_READ = 7'h04, D_CONV = 7'h08,
		D_COPY = 7'h10, D_RECALL = 7'h20, D_POWER = 7'h40
	} tsa_dst_t;
	typedef enum logic [6:0] {
		M_IDLE = 7'h01, M_CMD = 7'h02, M_WR = 7'h04, M_SLOT = 7'h08,
		M_WAIT = 7'h10, M_SPU = 7'h20, M_APOLL = 7'h40
	} tsa_mst_t;

	// Check code, LSB first, over the low n bits
	function automatic logic [7:0] tsa_crc8(input logic [63:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (i < n) begin
				c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
			end
		end
		return c;
	endfunction

endpackage

// >>> rtl/tsa_link_if.sv
/*
 * Command-level link between the bus controller and the thermometer.
 * Assumes both ends run on the same clock; the bench joins the modports.
 */
`timescale 1ns/10ps
interface tsa_link_if;
	logic m_cmd_vld; // Command strobe
	logic [7:0] m_cmd; // Command code
	logic m_wbit_vld; // Write slot strobe
	logic m_wbit; // Write slot bit
	logic m_rslot; // Read slot strobe
	logic m_spu; // Strong pull-up active
	logic m_apoll; // Alarm poll strobe
	logic d_rbit_vld; // Read slot answer strobe
	logic d_rbit; // Read slot bit, 0 means line pulled low
	logic d_apoll_ack; // Device takes part in alarm poll

	modport dev (input m_cmd_vld, m_cmd, m_wbit_vld, m_wbit, m_rslot, m_spu, m_apoll,
		output d_rbit_vld, d_rbit, d_apoll_ack);
	modport mst (output m_cmd_vld, m_cmd, m_wbit_vld, m_wbit, m_rslot, m_spu, m_apoll,
		input d_rbit_vld, d_rbit, d_apoll_ack);
endinterface

// >>> rtl/tsa_device.sv
/*
 * Thermometer device end: scratchpad, nonvolatile limits and resolution,
 * conversion timing, alarm flag, identity code and read slot answers.
 * Assumes the controller keeps its side of the link and supplies power.
 */
// What this block does
// RULE1: Compare result bits 11:4 signed against limits
// RULE2: Alarm when at or beyond either limit
// RULE3: Re-evaluate alarm after every finished conversion
// RULE4: Answer alarm poll only with flag set
// RULE5: Controller reconverts after limits change during alarm
// RULE6: Controller enables strong pull-up within 10us
// RULE7: Pull-up held for conversion or 10ms
// RULE8: Power query slot low when parasite powered
// RULE9: Identity code: family, serial, check byte
// RULE10: Bytes 0,1 are result, never written
// RULE11: Bytes 2,3 limits, byte 4 configuration
// RULE12: Bytes 5 to 7 ignore writes
// RULE13: Byte 8 is check code of 0-7
// RULE14: Write sends bytes 2,3,4 LSB first
// RULE15: Read sends from byte 0 LSB upward
// RULE16: Store copies limits and configuration to nonvolatile
// RULE17: Power-up loads nonvolatile into scratchpad
// RULE18: Restore reloads; slots read 0 busy, 1 done
// RULE19: Bits 6:5 pick 9 to 12 bit timing
// RULE20: Resolution defaults to 12 bits
// RULE21: Config bit 7 reads 0, bits 4:0 read 1
// RULE22: Result is 16-bit sign-extended two's complement
// RULE23: Idle until convert command, then idle again
`timescale 1ns/10ps
module tsa_device
	import tsa_pkg::*;
#(
	parameter int CONV_MAX_CYC = CONV_CYC_DEF, // 12-bit conversion time in cycles
	parameter int NV_WR_CYC = NV_WR_CYC_DEF, // Nonvolatile write time in cycles
	parameter logic [7:0] FAMILY_CODE = 8'h5A, // Arbitrary value
	parameter logic [47:0] SERIAL_NUM = 48'h0123456789AB // Arbitrary value
) (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	tsa_link_if.dev link, // Link to controller
	input wire logic [15:0] temp_in, // Raw sensor result, same clock
	input wire logic parasite_mode, // High when powered from the line
	output logic [63:0] id_code, // Identity code
	output logic alarm_flag, // Alarm flag level
	output logic busy // Conversion, store or restore running
);

	// ==========================================================
	// State and storage
	tsa_dst_t state_reg, state_next;
	logic [31:0] cnt_reg;
	logic [15:0] temp_reg;
	logic [7:0] upper_reg, lower_reg, nv_upper_reg, nv_lower_reg;
	logic [1:0] res_reg, nv_res_reg;
	logic alarm_reg;
	logic load_pend_reg;
	logic [7:0] wsh_reg;
	logic [2:0] wbit_cnt_reg;
	logic [1:0] wbyte_reg;
	logic [6:0] ridx_reg;
	logic rbit_vld_reg, rbit_reg;
	logic [1:0] pm_sync_reg;

	// ==========================================================
	// Decoding
	wire timed = (state_reg == D_CONV) || (state_reg == D_COPY) || (state_reg == D_RECALL);
	wire cmd_take = link.m_cmd_vld && !timed;
	wire timer_done = timed && (cnt_reg == 32'h0000_0000);
	wire conv_done = (state_reg == D_CONV) && timer_done;
	wire copy_done = (state_reg == D_COPY) && timer_done;
	wire reload = load_pend_reg || ((state_reg == D_RECALL) && timer_done);
	wire wr_take = link.m_wbit_vld && (state_reg == D_WRITE);
	wire wbyte_end = wr_take && (wbit_cnt_reg == BIT_LAST);
	wire [7:0] wbyte_val = {link.m_wbit, wsh_reg[7:1]};
	// Low resolutions finish in a power-of-two fraction of the full time
	wire [31:0] conv_cyc = 32'(CONV_MAX_CYC) >> (RES_MAX - res_reg); // RULE19
	// Fixed bits are rebuilt on every read, so writes never reach them
	wire [7:0] cfg_byte = {CFG_TOP_VAL, res_reg, CFG_LOW_VAL}; // RULE21
	wire [63:0] sp_data = {RSV7_VAL, RSV6_VAL, RSV5_VAL, cfg_byte, lower_reg, upper_reg,
		temp_reg}; // RULE10 RULE11 RULE12
	wire [71:0] sp_all = {tsa_crc8(sp_data, SP_DATA_BITS), sp_data}; // RULE13
	wire [55:0] rom_data = {SERIAL_NUM, FAMILY_CODE};
	wire [7:0] t_cmp = temp_in[CMP_HI:CMP_LO]; // RULE1
	wire alarm_now = ($signed(t_cmp) <= $signed(lower_reg))
		|| ($signed(t_cmp) >= $signed(upper_reg)); // RULE1 RULE2

	// Identity code, check byte on top of family and serial
	assign id_code = {tsa_crc8({8'h00, rom_data}, ROM_DATA_BITS), rom_data}; // RULE9
	assign alarm_flag = alarm_reg;
	assign busy = timed;
	assign link.d_apoll_ack = link.m_apoll && alarm_reg; // RULE4
	assign link.d_rbit_vld = rbit_vld_reg;
	assign link.d_rbit = rbit_reg;

	// ==========================================================
	// Command sequencing; commands during a timed job are ignored
	always_comb begin
		state_next = state_reg;
		if (cmd_take) begin
			case (link.m_cmd)
				CMD_CONVERT: state_next = D_CONV; // RULE23
				CMD_WRITE_SP: state_next = D_WRITE;
				CMD_READ_SP: state_next = D_READ;
				CMD_COPY_SP: state_next = D_COPY;
				CMD_RECALL: state_next = D_RECALL;
				CMD_READ_PWR: state_next = D_POWER;
				default: state_next = D_IDLE;
			endcase
		end else if (timer_done) begin
			state_next = D_IDLE; // RULE23
		end else if (wbyte_end && wbyte_reg == WBYTE_CFG) begin
			state_next = D_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_reg <= D_IDLE; // RULE23
		end else begin
			state_reg <= state_next;
		end
	end

	// Job timer, loaded when a timed command is taken
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_reg <= 32'h0000_0000;
		end else if (cmd_take && link.m_cmd == CMD_CONVERT) begin
			cnt_reg <= conv_cyc - 32'h0000_0001; // RULE19
		end else if (cmd_take && link.m_cmd == CMD_COPY_SP) begin
			cnt_reg <= 32'(NV_WR_CYC) - 32'h0000_0001;
		end else if (cmd_take && link.m_cmd == CMD_RECALL) begin
			cnt_reg <= 32'(RECALL_CYC) - 32'h0000_0001;
		end else if (cnt_reg != 32'h0000_0000) begin
			cnt_reg <= cnt_reg - 32'h0000_0001;
		end
	end

	// ==========================================================
	// Result and alarm flag, both updated only at conversion end
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			temp_reg <= TEMP_RESET;
			alarm_reg <= 1'b0;
		end else if (conv_done) begin
			temp_reg <= temp_in; // RULE22
			alarm_reg <= alarm_now; // RULE3
		end
	end

	// ==========================================================
	// Nonvolatile copy; its reset stands for the stored contents
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			nv_upper_reg <= NV_UPPER_INIT;
			nv_lower_reg <= NV_LOWER_INIT;
			nv_res_reg <= NV_RES_INIT; // RULE20
		end else if (copy_done) begin
			nv_upper_reg <= upper_reg; // RULE16
			nv_lower_reg <= lower_reg; // RULE16
			nv_res_reg <= res_reg; // RULE16
		end
	end

	// One cycle after reset release the scratchpad takes the stored values
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			load_pend_reg <= 1'b1;
		end else begin
			load_pend_reg <= 1'b0; // RULE17
		end
	end

	// ==========================================================
	// Writable scratchpad bytes, filled LSB first in byte order
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			upper_reg <= NV_UPPER_INIT;
			lower_reg <= NV_LOWER_INIT;
			res_reg <= NV_RES_INIT; // RULE20
		end else if (reload) begin
			upper_reg <= nv_upper_reg; // RULE17 RULE18
			lower_reg <= nv_lower_reg; // RULE17 RULE18
			res_reg <= nv_res_reg; // RULE17 RULE18
		end else if (wbyte_end) begin
			if (wbyte_reg == WBYTE_UPPER) begin
				upper_reg <= wbyte_val; // RULE14
			end
			if (wbyte_reg == WBYTE_LOWER) begin
				lower_reg <= wbyte_val; // RULE14
			end
			if (wbyte_reg == WBYTE_CFG) begin
				res_reg <= wbyte_val[CFG_RES_HI:CFG_RES_LO]; // RULE14 RULE21
			end
		end
	end

	// Write shifter and bit/byte position
	always_ff @(posedge mclk) begin
		if (!rst_b || cmd_take) begin
			wsh_reg <= 8'h00;
			wbit_cnt_reg <= 3'h0;
			wbyte_reg <= WBYTE_UPPER;
		end else if (wr_take) begin
			wsh_reg <= wbyte_val; // RULE14
			wbit_cnt_reg <= wbit_cnt_reg + 3'h1;
			if (wbyte_end) begin
				wbyte_reg <= wbyte_reg + 2'h1;
			end
		end
	end

	// ==========================================================
	// Read slot answers, one cycle after the slot strobe
	// Power strap arrives from a pin, so two flops guard it before use
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pm_sync_reg <= 2'h0;
		end else begin
			pm_sync_reg <= {pm_sync_reg[0], parasite_mode};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || cmd_take) begin
			ridx_reg <= 7'h00;
		end else if (link.m_rslot && state_reg == D_READ && ridx_reg != 7'(SP_BITS)) begin
			ridx_reg <= ridx_reg + 7'h01; // RULE15
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rbit_vld_reg <= 1'b0;
			rbit_reg <= 1'b1;
		end else begin
			rbit_vld_reg <= link.m_rslot;
			if (link.m_rslot) begin
				unique case (state_reg)
					// Past the last byte the line is simply left released
					D_READ: rbit_reg <= (ridx_reg < 7'(SP_BITS)) ? sp_all[ridx_reg] : 1'b1; // RULE15
					D_POWER: rbit_reg <= !pm_sync_reg[1]; // RULE8
					D_CONV, D_COPY, D_RECALL: rbit_reg <= 1'b0; // RULE18
					D_IDLE, D_WRITE: rbit_reg <= 1'b1; // RULE18
				endcase
			end
		end
	end

endmodule

// >>> rtl/tsa_master.sv
/*
 * Controller end of the thermometer link, steered by APB registers.
 * Assumes a single APB master and one device on the link.
 */
`timescale 1ns/10ps
module tsa_master
	import tsa_pkg::*;
#(
	parameter int CONV_MAX_CYC = CONV_CYC_DEF, // Pull-up time, 12-bit conversion
	parameter int NV_WR_CYC = NV_WR_CYC_DEF // Pull-up time, nonvolatile store
) (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data, registered
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	tsa_link_if.mst link // Link to device
);

	// ==========================================================
	// Registers
	tsa_mst_t state_reg, state_next;
	logic [7:0] cmd_reg;
	logic [23:0] wdat_reg;
	logic spu_en_reg, poll_reg, last_bit_reg, apoll_ack_reg;
	logic [1:0] res_reg;
	logic [71:0] rdat_reg;
	logic [6:0] bit_cnt_reg, nbits_reg;
	logic [31:0] cnt_reg, prdata_reg;

	// ==========================================================
	// APB decode; always ready, no wait states
	wire idle = (state_reg == M_IDLE);
	wire addr_ok = (paddr == REG_CTRL) || (paddr == REG_WDATA) || (paddr == REG_STATUS)
		|| (paddr == REG_RDATA0) || (paddr == REG_RDATA1) || (paddr == REG_RDATA2);
	wire wr_en = psel && penable && pwrite;
	wire ctrl_wr = wr_en && paddr == REG_CTRL && idle; // Ignored while busy
	wire go = ctrl_wr && pwdata[CTRL_GO];
	wire apoll_go = ctrl_wr && pwdata[CTRL_APOLL] && !pwdata[CTRL_GO];
	wire [7:0] ncmd = cmd_reg;
	wire timed_cmd = (ncmd == CMD_CONVERT) || (ncmd == CMD_COPY_SP);
	wire poll_cmd = timed_cmd || (ncmd == CMD_RECALL);
	wire [31:0] spu_cyc = (ncmd == CMD_COPY_SP) ? 32'(NV_WR_CYC) : (32'(CONV_MAX_CYC) >> (RES_MAX - res_reg));
	wire slot_last = (bit_cnt_reg == nbits_reg - 7'h01);
	wire [31:0] status = {28'h0000000, last_bit_reg, apoll_ack_reg, link.m_spu, !idle};

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_reg;
	assign link.m_cmd_vld = (state_reg == M_CMD);
	assign link.m_cmd = cmd_reg;
	assign link.m_wbit_vld = (state_reg == M_WR);
	assign link.m_wbit = wdat_reg[bit_cnt_reg[4:0]]; // RULE14
	assign link.m_rslot = (state_reg == M_SLOT);
	// Pull-up comes the cycle after the command, far inside the limit
	assign link.m_spu = (state_reg == M_SPU); // RULE6
	assign link.m_apoll = (state_reg == M_APOLL);

	// ==========================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			M_IDLE: state_next = go ? M_CMD : (apoll_go ? M_APOLL : M_IDLE);
			M_CMD: begin
				if (ncmd == CMD_WRITE_SP) begin
					state_next = M_WR;
				end else if (timed_cmd && spu_en_reg) begin
					state_next = M_SPU; // RULE6
				end else if (poll_cmd || ncmd == CMD_READ_SP || ncmd == CMD_READ_PWR) begin
					state_next = M_SLOT;
				end else begin
					state_next = M_IDLE;
				end
			end
			M_WR: state_next = (bit_cnt_reg == 7'(WR_BITS - 1)) ? M_IDLE : M_WR;
			M_SLOT: state_next = M_WAIT;
			M_WAIT: begin
				if (link.d_rbit_vld) begin
					state_next = (poll_reg ? link.d_rbit : slot_last) ? M_IDLE : M_SLOT;
				end
			end
			M_SPU: state_next = (cnt_reg == 32'h0000_0000) ? M_IDLE : M_SPU; // RULE7
			M_APOLL: state_next = M_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_reg <= M_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Orders from software
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cmd_reg <= 8'h00;
			wdat_reg <= 24'h000000;
			spu_en_reg <= 1'b0;
			res_reg <= RES_MAX;
		end else begin
			if (ctrl_wr) begin
				cmd_reg <= pwdata[7:0];
				spu_en_reg <= pwdata[CTRL_SPU];
				res_reg <= pwdata[CTRL_RES_HI:CTRL_RES_LO];
			end
			if (wr_en && paddr == REG_WDATA && idle) begin
				wdat_reg <= pwdata[23:0];
			end
		end
	end

	// Bit counting, pull-up timing, and captured answers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bit_cnt_reg <= 7'h00;
			nbits_reg <= 7'h01;
			poll_reg <= 1'b0;
			cnt_reg <= 32'h0000_0000;
			rdat_reg <= 72'h0;
			last_bit_reg <= 1'b0;
			apoll_ack_reg <= 1'b0;
		end else begin
			if (state_reg == M_CMD) begin
				bit_cnt_reg <= 7'h00;
				nbits_reg <= (ncmd == CMD_READ_SP) ? 7'(SP_BITS) : 7'h01;
				poll_reg <= poll_cmd;
				cnt_reg <= spu_cyc - 32'h0000_0001; // RULE7
			end else if (state_reg == M_WR || (state_reg == M_WAIT && link.d_rbit_vld)) begin
				bit_cnt_reg <= bit_cnt_reg + 7'h01;
			end else if (state_reg == M_SPU && cnt_reg != 32'h0000_0000) begin
				cnt_reg <= cnt_reg - 32'h0000_0001;
			end
			if (state_reg == M_WAIT && link.d_rbit_vld) begin
				last_bit_reg <= link.d_rbit;
				if (!poll_reg) begin
					rdat_reg <= {link.d_rbit, rdat_reg[71:1]};
				end
			end
			if (state_reg == M_APOLL) begin
				apoll_ack_reg <= link.d_apoll_ack;
			end
		end
	end

	// Read data registered in the setup phase
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (1'b1)
				paddr == REG_CTRL: prdata_reg <= {20'h00000, res_reg, spu_en_reg, 1'b0, cmd_reg};
				paddr == REG_WDATA: prdata_reg <= {8'h00, wdat_reg};
				paddr == REG_STATUS: prdata_reg <= status;
				paddr == REG_RDATA0: prdata_reg <= rdat_reg[31:0];
				paddr == REG_RDATA1: prdata_reg <= rdat_reg[63:32];
				paddr == REG_RDATA2: prdata_reg <= {24'h000000, rdat_reg[71:64]};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// >>> verif/tsa_checker.sv
/*
 * Link checker for the thermometer pair: slot answers, write bursts,
 * strong pull-up discipline and alarm poll answers.
 * Assumes it sits beside the one link joining the two design ends.
 */
`timescale 1ns/10ps
module tsa_checker
	import tsa_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic m_cmd_vld, // Command strobe
	input wire logic [7:0] m_cmd, // Command code
	input wire logic m_wbit_vld, // Write slot strobe
	input wire logic m_rslot, // Read slot strobe
	input wire logic m_spu, // Strong pull-up on
	input wire logic m_apoll, // Alarm poll strobe
	input wire logic d_rbit_vld, // Slot answer strobe
	input wire logic d_rbit, // Slot answer bit
	input wire logic d_apoll_ack // Poll answer
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Link relations
	AST_SLOT_ANSWER: assert property (m_rslot |=> d_rbit_vld)
		else $error("read slot got no answer");
	AST_ANSWER_CAUSE: assert property (d_rbit_vld |-> $past(m_rslot))
		else $error("answer without a read slot");
	AST_POLL_ONLY: assert property (d_apoll_ack |-> m_apoll)
		else $error("poll answer outside a poll");
	AST_WRITE_BITS: assert property (m_cmd_vld && m_cmd == CMD_WRITE_SP |=> m_wbit_vld [*8])
		else $error("write burst broken");
	AST_SPU_START: assert property ($rose(m_spu) |->
		$past(m_cmd_vld) && (m_cmd == CMD_CONVERT || m_cmd == CMD_COPY_SP))
		else $error("pull-up not right after convert or store");
	// Pull-up time is for power only, so the line must stay quiet
	AST_SPU_QUIET: assert property (m_spu |-> !(m_cmd_vld || m_rslot || m_wbit_vld || m_apoll))
		else $error("traffic under strong pull-up");
	AST_PWR_SLOT: assert property (m_cmd_vld && m_cmd == CMD_READ_PWR |-> ##[1:4] d_rbit_vld)
		else $error("power query unanswered");
	AST_RECALL_DONE: assert property (m_cmd_vld && m_cmd == CMD_RECALL |-> ##[1:60] (d_rbit_vld && d_rbit))
		else $error("restore never reported done");

	// ==========================================================
	// Main scenarios reached
	cover property (d_apoll_ack);
	cover property ($rose(m_spu));
	cover property (d_rbit_vld && !d_rbit);
endmodule

// >>> verif/tb_thermometer_scratchpad_alarm.sv
/*
 * Self-checking bench: APB controller driving the thermometer end.
 * Assumes shortened timing parameters on both ends and zero-wait APB.
 */
`timescale 1ns/10ps
module tb_thermometer_scratchpad_alarm
	import tsa_pkg::*;
;
	localparam int CONV = 800;
	localparam int NVW = 50;
	localparam logic [7:0] FAM = 8'hA5; // Arbitrary value
	localparam logic [47:0] SER = 48'h0BADC0FFEE42; // Arbitrary value
	logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, parasite_mode = 0, pready, pslverr, err;
	logic alarm_flag, busy;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] temp_in = 16'h0000;
	logic [63:0] id_code;
	logic [15:0] tt [4] = '{16'h0191, 16'h0180, 16'hFF6F, 16'hFF70};
	logic al [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int fail_count = 0, n_tests = 0, bcyc = 0, zslots = 0, b0 = 0, z0 = 0;

	// ==========================================================
	// Clock, watchers, design
	tsa_link_if link();
	always #2.5 mclk = ~mclk;
	// Busy length and zero answers, counted independently of the design
	always @(posedge mclk) begin
		if (busy === 1'b1) bcyc <= bcyc + 1;
		if (link.d_rbit_vld === 1'b1 && link.d_rbit === 1'b0) zslots <= zslots + 1;
	end
	tsa_master #(.CONV_MAX_CYC(CONV), .NV_WR_CYC(NVW)) tsa_master_i (.mclk(mclk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.mst));
	tsa_device #(.CONV_MAX_CYC(CONV), .NV_WR_CYC(NVW), .FAMILY_CODE(FAM), .SERIAL_NUM(SER)) tsa_device_i (
		.mclk(mclk), .rst_b(rst_b), .link(link.dev), .temp_in(temp_in), .parasite_mode(parasite_mode),
		.id_code(id_code), .alarm_flag(alarm_flag), .busy(busy));
	tsa_checker tsa_checker_i (.mclk(mclk), .rst_b(rst_b), .m_cmd_vld(link.m_cmd_vld), .m_cmd(link.m_cmd),
		.m_wbit_vld(link.m_wbit_vld), .m_rslot(link.m_rslot), .m_spu(link.m_spu), .m_apoll(link.m_apoll),
		.d_rbit_vld(link.d_rbit_vld), .d_rbit(link.d_rbit), .d_apoll_ack(link.d_apoll_ack));

	// ==========================================================
	// Helpers
	// Own check code, LSB first; kept apart from the design's function
	function automatic logic [7:0] crc(input logic [63:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
		return c;
	endfunction
	function automatic logic [63:0] sp(input logic [15:0] t, input logic [7:0] u, l, c);
		return {RSV7_VAL, RSV6_VAL, RSV5_VAL, c, l, u, t};
	endfunction
	task chk(input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		n = 0;
		do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin chk(0, 1); tally_and_finish(); end
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// Issue a link command and poll until both ends are idle
	task run(input logic [7:0] cmd, input logic spu, input logic [1:0] r);
		int n;
		apb(1, REG_CTRL, {20'h0, r, spu, 1'b1, cmd});
		n = 0;
		do begin apb(0, REG_STATUS, 0); n++; end while ((rd[0] !== 1'b0 || busy !== 1'b0) && n < 600);
		if (n >= 600) begin chk(0, 1); tally_and_finish(); end
	endtask
	task wsp(input logic [23:0] w);
		apb(1, REG_WDATA, {8'h0, w});
		run(CMD_WRITE_SP, 0, 3);
	endtask
	task rsp(input logic [63:0] e);
		run(CMD_READ_SP, 0, 3);
		apb(0, REG_RDATA0, 0); chk(rd, e[31:0]);
		apb(0, REG_RDATA1, 0); chk(rd, e[63:32]);
		apb(0, REG_RDATA2, 0); chk(rd, {24'h0, crc(e, 64)});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		chk(busy, 0);
		chk(id_code, {crc({8'h0, SER, FAM}, 56), SER, FAM});
		rsp(sp(TEMP_RESET, NV_UPPER_INIT, NV_LOWER_INIT, 8'h7F));
		$display("test powerup done");
		// Each resolution once; temperatures hit both limits exactly
		for (int r = 0; r < 4; r++) begin
			temp_in <= tt[r];
			wsp({1'b1, r[1:0], 5'h00, 8'hF6, 8'h19});
			b0 = bcyc;
			// Limits just changed, so a fresh conversion comes before the flag is trusted
			run(CMD_CONVERT, r[0], r[1:0]);
			chk(bcyc - b0 >= (CONV >> (3 - r)) && bcyc - b0 <= (CONV >> (3 - r)) + 2, 1);
			chk(alarm_flag, al[r]);
			apb(1, REG_CTRL, 32'h1000);
			apb(0, REG_STATUS, 0); chk(rd[2], al[r]);
			rsp(sp(tt[r], 8'h19, 8'hF6, {1'b0, r[1:0], 5'h1F}));
		end
		$display("test resolution and alarm done");
		for (int p = 0; p < 2; p++) begin
			parasite_mode <= p[0];
			run(CMD_READ_PWR, 0, 3);
			apb(0, REG_STATUS, 0); chk(rd[3], !p[0]);
		end
		$display("test power query done");
		wsp(24'h3FCC33);
		run(CMD_COPY_SP, 1, 3);
		apb(0, REG_CTRL, 0); chk(rd, {20'h00000, 2'h3, 1'b1, 1'b0, CMD_COPY_SP});
		apb(0, REG_WDATA, 0); chk(rd, 32'h003FCC33);
		wsp(24'h1F5544);
		z0 = zslots;
		run(CMD_RECALL, 0, 3);
		chk(zslots > z0, 1);
		rsp(sp(tt[3], 8'h33, 8'hCC, 8'h3F));
		$display("test store and restore done");
		apb(0, 8'h40, 0);
		chk({err, rd}, {1'b1, 32'h0});
		$display("test unmapped access done");
		tally_and_finish();
	end
endmodule
